// ==== mtp_mac_tx.v ====
// MAC transmit path with 802.3x pause frame generation.
// Assumes a byte source on the system clock and a GMII transmit clock from the serializer.
`timescale 1ns/10ps
`include "mtp_map.vh"

module mtp_mac_tx (
  input wire i_mclk,
  input wire i_rst_n,
  input wire i_tx_clk,
  input wire i_crs,
  input wire i_col,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  input wire i_pkt_valid,
  input wire [7:0] i_pkt_data,
  input wire i_pkt_last,
  input wire i_pkt_pass_crc,
  output reg o_pkt_ready,
  output reg o_pkt_rewind,
  output reg o_pkt_done,
  output reg o_pkt_drop,
  input wire i_flow_req,
  input wire i_short_gap,
  output reg [7:0] o_txd,
  output reg o_tx_en,
  output reg o_tx_er
);

  localparam S_IDLE = 3'd0;
  localparam S_PRE = 3'd1;
  localparam S_DATA = 3'd2;
  localparam S_PAUSE = 3'd3;
  localparam S_FCS = 3'd4;
  localparam S_JAM = 3'd5;
  localparam S_BACKOFF = 3'd6;
  // Short gap in byte ticks, sized to the gap register
  localparam [8:0] SHORT_TICKS = `MTP_SHORT_TICKS;

  // One CRC-32 step, reflected, so bits are consumed LSB first
  function [31:0] crc_next;
    input [31:0] crc;
    input [7:0] data;
    integer i;
    reg [31:0] c;
    begin
      c = crc;
      for (i = 0; i < 8; i = i + 1) begin
        if (c[0] ^ data[i])
          c = (c >> 1) ^ `MTP_CRC_POLY;
        else
          c = c >> 1;
      end
      crc_next = c;
    end
  endfunction

  // Pause frame body byte by index, multi-byte fields high byte first
  function [7:0] pause_byte;
    input [10:0] idx;
    input [31:0] sa_up;
    input [15:0] sa_lo;
    input zero;
    reg [15:0] pmax;
    begin
      pmax = `MTP_PAUSE_MAX;
      case (idx)
        11'd0: pause_byte = 8'h01;
        11'd1: pause_byte = 8'h80;
        11'd2: pause_byte = 8'hC2;
        11'd3: pause_byte = 8'h00;
        11'd4: pause_byte = 8'h00;
        11'd5: pause_byte = 8'h01;
        11'd6: pause_byte = sa_up[31:24];
        11'd7: pause_byte = sa_up[23:16];
        11'd8: pause_byte = sa_up[15:8];
        11'd9: pause_byte = sa_up[7:0];
        11'd10: pause_byte = sa_lo[15:8];
        11'd11: pause_byte = sa_lo[7:0];
        11'd12: pause_byte = 8'h88;
        11'd13: pause_byte = 8'h08;
        11'd14: pause_byte = 8'h00;
        11'd15: pause_byte = 8'h01;
        11'd16: pause_byte = zero ? 8'h00 : pmax[15:8];
        11'd17: pause_byte = zero ? 8'h00 : pmax[7:0];
        default: pause_byte = 8'h00;
      endcase
    end
  endfunction

  // Back-off slot mask for attempt n, exponent capped at ten
  function [9:0] bo_mask;
    input [4:0] n;
    begin
      if (n >= `MTP_BO_LIMIT)
        bo_mask = 10'h3FF;
      else
        bo_mask = (10'h001 << n) - 10'h001;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Synchronisers and link tick

  reg clk_s1_q, clk_s2_q, clk_s3_q;
  reg crs_s1_q, crs_s2_q;
  reg col_s1_q, col_s2_q;
  wire tick;

  // Link clock and carrier pins come from another domain
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      crs_s1_q <= 1'b0;
      crs_s2_q <= 1'b0;
      col_s1_q <= 1'b0;
      col_s2_q <= 1'b0;
    end else begin
      clk_s1_q <= i_tx_clk;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      crs_s1_q <= i_crs;
      crs_s2_q <= crs_s1_q;
      col_s1_q <= i_col;
      col_s2_q <= col_s1_q;
    end
  end

  // One byte time per rising link clock edge
  assign tick = clk_s2_q & ~clk_s3_q;

  //////////////////////////////////////////////////////////////////////////////
  // Register file

  reg [3:0] ctrl_q;
  reg [8:0] gap_q;
  reg [31:0] sa_up_q;
  reg [15:0] sa_lo_q;
  reg [2:0] st_q;
  reg [15:0] pause_cnt_q;
  reg [4:0] pace_q;
  reg pause_act_q, pend_q, pend_zero_q;

  // Writes take effect in the cycle after the strobe
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q <= `MTP_CTRL_RST;
      gap_q <= `MTP_GAP_RST;
      sa_up_q <= 32'h00000000;
      sa_lo_q <= 16'h0000;
    end else if (i_wr) begin
      case (i_addr)
        `MTP_ADDR_CTRL: ctrl_q <= i_wdata[3:0];
        `MTP_ADDR_GAP: gap_q <= i_wdata[8:0];
        `MTP_ADDR_SA_UP: sa_up_q <= i_wdata;
        `MTP_ADDR_SA_LO: sa_lo_q <= i_wdata[15:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  // Read data stands for exactly one cycle; unmapped reads return zero
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n)
      o_rdata <= 32'h00000000;
    else if (i_rd) begin
      case (i_addr)
        `MTP_ADDR_CTRL: o_rdata <= {28'h0000000, ctrl_q};
        `MTP_ADDR_GAP: o_rdata <= {23'h000000, gap_q};
        `MTP_ADDR_SA_UP: o_rdata <= sa_up_q;
        `MTP_ADDR_SA_LO: o_rdata <= {16'h0000, sa_lo_q};
        `MTP_ADDR_STAT: o_rdata <= {1'b0, st_q, 1'b0, pend_zero_q, pend_q, pause_act_q, 3'h0, pace_q, pause_cnt_q};
        default: o_rdata <= 32'h00000000;
      endcase
    end else
      o_rdata <= 32'h00000000;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pause request tracking

  wire half = ~ctrl_q[`MTP_CTRL_DUPLEX];
  // No input from received pause frames reaches here, so incoming pause never holds this off
  wire flow_eff = ctrl_q[`MTP_CTRL_DUPLEX] & ctrl_q[`MTP_CTRL_FLOW] & i_flow_req;
  reg [5:0] quanta_q;
  reg is_pause_q, pz_q;
  wire pause_start;

  // Quantum is 512 bit times, 64 byte ticks; the six-bit counter wraps at that
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      quanta_q <= 6'h00;
      pause_cnt_q <= 16'h0000;
      pause_act_q <= 1'b0;
      pend_q <= 1'b0;
      pend_zero_q <= 1'b0;
    end else begin
      if (tick)
        quanta_q <= quanta_q + 6'h01;
      if (pause_start) begin
        pend_q <= 1'b0;
        if (!pend_zero_q)
          pause_cnt_q <= `MTP_PAUSE_RELOAD;
      end else if (tick && quanta_q == 6'h3F && pause_cnt_q != 16'h0000) begin
        pause_cnt_q <= pause_cnt_q - 16'h0001;
        if (pause_cnt_q == 16'h0001 && pause_act_q && flow_eff) begin
          pend_q <= 1'b1;
          pend_zero_q <= 1'b0;
        end
      end
      // New events come after the clear so a set in the same cycle wins
      if (pause_act_q && !flow_eff) begin
        pause_act_q <= 1'b0;
        pause_cnt_q <= 16'h0000;
        pend_q <= 1'b1;
        pend_zero_q <= 1'b1;
      end else if (!pause_act_q && flow_eff) begin
        pause_act_q <= 1'b1;
        pend_q <= 1'b1;
        pend_zero_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Gap, pacing and start decision

  reg [10:0] gap_cnt_q, body_cnt_q;
  reg col_frame_q, deferred_q;
  reg [4:0] attempts_q;
  reg [15:0] lfsr_q;
  wire tx_busy = (st_q != S_IDLE) && (st_q != S_BACKOFF);
  wire crs_win = ~col_frame_q && (gap_cnt_q < `MTP_CRS_WIN_TICKS);
  wire crs_hold = half & crs_s2_q & ~crs_win;
  wire [8:0] gap_base = (ctrl_q[`MTP_CTRL_SGAP] & i_short_gap) ? SHORT_TICKS : gap_q;
  wire pace_slow = ctrl_q[`MTP_CTRL_PACE] && pace_q != 5'h00 && attempts_q == 5'h00;
  wire [10:0] need = pace_slow ? {gap_base, 2'b00} : {2'b00, gap_base};
  wire gap_ok = (st_q == S_IDLE) && !crs_hold && (gap_cnt_q >= need);
  wire start_data = gap_ok && !pend_q && i_pkt_valid;
  wire base_ok = (st_q == S_IDLE) && !crs_hold && (gap_cnt_q >= {2'b00, gap_base});
  assign pause_start = tick && base_ok && pend_q;

  // Gap is counted from enable drop, restarted by late carrier in half duplex only
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gap_cnt_q <= 11'h000;
      deferred_q <= 1'b0;
      lfsr_q <= 16'hACE1;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      if (tick) begin
        if (tx_busy)
          gap_cnt_q <= 11'h000;
        else if (crs_hold)
          gap_cnt_q <= 11'h000;
        else if (gap_cnt_q != 11'h7FF)
          gap_cnt_q <= gap_cnt_q + 11'h001;
      end
      // Deferral mark cleared as a frame ends after its FCS; a frame dropped for excessive collisions leaves it set
      if (tick && st_q == S_FCS && fcs_n_q == 3'h4)
        deferred_q <= 1'b0;
      else if (tick && st_q == S_IDLE && crs_hold && i_pkt_valid)
        deferred_q <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Transmit state machine

  reg [2:0] pre_cnt_q, fcs_n_q;
  reg [31:0] crc_q, fcs_q;
  reg [15:0] bo_cnt_q;
  wire [31:0] crc_pkt = crc_next(crc_q, i_pkt_data);
  wire [7:0] pbyte = pause_byte(body_cnt_q, sa_up_q, sa_lo_q, pz_q);
  wire [31:0] crc_pse = crc_next(crc_q, pbyte);
  wire [4:0] att_n = attempts_q + 5'h01;
  wire [9:0] slots = lfsr_q[9:0] & bo_mask(att_n);
  wire col_hit = half && col_s2_q && (st_q == S_PRE || st_q == S_DATA || st_q == S_PAUSE || st_q == S_FCS);

  // Byte-wide datapath, advances once per link tick
  always @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_q <= S_IDLE;
      o_txd <= 8'h00;
      o_tx_en <= 1'b0;
      o_tx_er <= 1'b0;
      o_pkt_ready <= 1'b0;
      o_pkt_rewind <= 1'b0;
      o_pkt_done <= 1'b0;
      o_pkt_drop <= 1'b0;
      pre_cnt_q <= 3'h0;
      fcs_n_q <= 3'h0;
      body_cnt_q <= 11'h000;
      crc_q <= `MTP_CRC_INIT;
      fcs_q <= 32'h00000000;
      bo_cnt_q <= 16'h0000;
      col_frame_q <= 1'b0;
      attempts_q <= 5'h00;
      pace_q <= 5'h00;
      is_pause_q <= 1'b0;
      pz_q <= 1'b0;
    end else begin
      o_tx_er <= 1'b0;
      o_pkt_ready <= 1'b0;
      o_pkt_rewind <= 1'b0;
      o_pkt_done <= 1'b0;
      o_pkt_drop <= 1'b0;
      if (tick) begin
        if (col_hit) begin
          col_frame_q <= 1'b1;
          if (body_cnt_q < `MTP_LATE_BYTES && !is_pause_q) begin
            st_q <= S_JAM;
            o_txd <= `MTP_JAM_BYTE;
            pre_cnt_q <= 3'h1;
            o_pkt_rewind <= 1'b1;
          end
        end
        if (!(col_hit && body_cnt_q < `MTP_LATE_BYTES && !is_pause_q)) begin
          case (st_q)
            S_IDLE: begin
              o_tx_en <= 1'b0;
              o_txd <= 8'h00;
              if (pause_start || start_data) begin
                is_pause_q <= pend_q;
                pz_q <= pend_zero_q;
                st_q <= S_PRE;
                o_tx_en <= 1'b1;
                o_txd <= `MTP_PRE_BYTE;
                pre_cnt_q <= 3'h1;
                body_cnt_q <= 11'h000;
                crc_q <= `MTP_CRC_INIT;
                if (attempts_q == 5'h00)
                  col_frame_q <= 1'b0;
              end
            end
            S_PRE: begin
              if (pre_cnt_q == 3'h7) begin
                o_txd <= `MTP_SFD_BYTE;
                st_q <= is_pause_q ? S_PAUSE : S_DATA;
              end else begin
                o_txd <= `MTP_PRE_BYTE;
                pre_cnt_q <= pre_cnt_q + 3'h1;
              end
            end
            S_DATA: begin
              if (i_pkt_valid) begin
                o_txd <= i_pkt_data;
                o_pkt_ready <= 1'b1;
                crc_q <= crc_pkt;
                if (body_cnt_q != 11'h7FF)
                  body_cnt_q <= body_cnt_q + 11'h001;
                if (i_pkt_last) begin
                  st_q <= S_FCS;
                  fcs_q <= ~crc_pkt;
                  fcs_n_q <= i_pkt_pass_crc ? 3'h4 : 3'h0;
                end
              end else begin
                // Starved mid-frame: send the raw remainder, a deliberately bad FCS
                o_txd <= crc_q[7:0];
                fcs_q <= {8'h00, crc_q[31:8]};
                fcs_n_q <= 3'h1;
                st_q <= S_FCS;
              end
            end
            S_PAUSE: begin
              o_txd <= pbyte;
              crc_q <= crc_pse;
              body_cnt_q <= body_cnt_q + 11'h001;
              if (body_cnt_q == `MTP_PAUSE_BODY - 11'h001) begin
                st_q <= S_FCS;
                fcs_q <= ~crc_pse;
                fcs_n_q <= 3'h0;
              end
            end
            S_FCS: begin
              if (fcs_n_q == 3'h4) begin
                o_tx_en <= 1'b0;
                o_txd <= 8'h00;
                st_q <= S_IDLE;
                if (!is_pause_q) begin
                  o_pkt_done <= 1'b1;
                  attempts_q <= 5'h00;
                  if (col_frame_q || deferred_q)
                    pace_q <= `MTP_PACE_LOAD;
                  else if (pace_q != 5'h00)
                    pace_q <= pace_q - 5'h01;
                end
              end else begin
                o_txd <= fcs_q[7:0];
                fcs_q <= {8'h00, fcs_q[31:8]};
                fcs_n_q <= fcs_n_q + 3'h1;
              end
            end
            S_JAM: begin
              if (pre_cnt_q == `MTP_JAM_LEN) begin
                o_tx_en <= 1'b0;
                o_txd <= 8'h00;
                attempts_q <= att_n;
                if (att_n == `MTP_ATTEMPT_MAX) begin
                  // Excessive collisions: give the frame up
                  st_q <= S_IDLE;
                  o_pkt_done <= 1'b1;
                  o_pkt_drop <= 1'b1;
                  attempts_q <= 5'h00;
                  pace_q <= `MTP_PACE_LOAD;
                end else begin
                  st_q <= S_BACKOFF;
                  bo_cnt_q <= {slots, 6'h00};
                end
              end else begin
                o_txd <= `MTP_JAM_BYTE;
                pre_cnt_q <= pre_cnt_q + 3'h1;
              end
            end
            S_BACKOFF: begin
              o_tx_en <= 1'b0;
              if (bo_cnt_q == 16'h0000)
                st_q <= S_IDLE;
              else
                bo_cnt_q <= bo_cnt_q - 16'h0001;
            end
            default: st_q <= S_IDLE;
          endcase
        end
      end
    end
  end

endmodule // mtp_mac_tx

// ==== mtp_mac_tx_asserts.sv ====
// Port checker for the MAC transmit block.
// Assumes one clock domain on i_mclk and the async active-low reset i_rst_n.
`timescale 1ns/10ps

module mtp_mac_tx_asserts (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_pkt_ready,
  input wire logic o_pkt_rewind,
  input wire logic o_pkt_done,
  input wire logic o_pkt_drop,
  input wire logic [7:0] o_txd,
  input wire logic o_tx_en,
  input wire logic o_tx_er
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Frame start: preamble byte, then enable held for eight system clock cycles
  sequence s_start;
    $rose(o_tx_en) ##0 (o_txd == 8'h55);
  endsequence
  sequence s_en_hold;
    o_tx_en [*8];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_err_idle: assert property (!o_tx_er)
    else $error("transmit error line driven");
  a_pre_byte: assert property ($rose(o_tx_en) |-> s_start)
    else $error("frame does not open with preamble");
  a_en_hold: assert property (s_start |-> s_en_hold)
    else $error("enable dropped inside preamble");
  a_done_fall: assert property (o_pkt_done && !o_pkt_drop |-> $fell(o_tx_en))
    else $error("done without end of frame");
  a_drop_done: assert property (o_pkt_drop |-> o_pkt_done)
    else $error("drop without done");
  a_ready_pulse: assert property (o_pkt_ready |=> !o_pkt_ready)
    else $error("ready longer than one cycle");
  a_ready_frame: assert property (o_pkt_ready |-> o_tx_en)
    else $error("byte taken outside a frame");
  a_rew_nodone: assert property (o_pkt_rewind |-> !o_pkt_done)
    else $error("rewind and done together");
  a_rd_quiet: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule // mtp_mac_tx_asserts

bind mtp_mac_tx mtp_mac_tx_asserts i_mtp_mac_tx_asserts (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_pkt_ready(o_pkt_ready), .o_pkt_rewind(o_pkt_rewind), .o_pkt_done(o_pkt_done),
  .o_pkt_drop(o_pkt_drop), .o_txd(o_txd), .o_tx_en(o_tx_en), .o_tx_er(o_tx_er));

// ==== mtp_map.vh ====
// Constants for the MAC transmit and pause generation block.
// Assumes a 50 MHz system clock and a GMII transmit clock sampled as a plain input.
`ifndef MTP_MAP_VH
`define MTP_MAP_VH
`define MTP_ADDR_CTRL 8'h00
`define MTP_ADDR_GAP 8'h04
`define MTP_ADDR_SA_UP 8'h08
`define MTP_ADDR_SA_LO 8'h0C
`define MTP_ADDR_STAT 8'h10
`define MTP_CTRL_DUPLEX 0
`define MTP_CTRL_FLOW 1
`define MTP_CTRL_PACE 2
`define MTP_CTRL_SGAP 3
`define MTP_CTRL_RST 4'h0
`define MTP_GAP_RST 9'h00C
`define MTP_PAUSE_MAX 16'hFFFF
`define MTP_PAUSE_RELOAD 16'hFF00
`define MTP_PACE_LOAD 5'h1F
`define MTP_BYTE_BITS 8
`define MTP_STD_GAP_BITS 96
`define MTP_SHORT_BITS 8
`define MTP_CRS_WIN_BITS 48
`define MTP_CRS_WIN_TICKS (`MTP_CRS_WIN_BITS / `MTP_BYTE_BITS)
`define MTP_SHORT_TICKS ((`MTP_STD_GAP_BITS - `MTP_SHORT_BITS) / `MTP_BYTE_BITS)
`define MTP_LATE_BYTES 11'h040
`define MTP_PAUSE_BODY 11'h03C
`define MTP_JAM_LEN 3'h4
`define MTP_ATTEMPT_MAX 5'h10
`define MTP_BO_LIMIT 5'h0A
`define MTP_PRE_BYTE 8'h55
`define MTP_SFD_BYTE 8'hD5
`define MTP_JAM_BYTE 8'hAA
`define MTP_CRC_INIT 32'hFFFFFFFF
`define MTP_CRC_POLY 32'hEDB88320
`endif

// ==== mtp_ser_model.sv ====
// Serializer-side model: free GMII transmit clock, carrier echo, frame capture.
// Assumes the MAC holds GMII data stable at each rising transmit clock edge.
`timescale 1ns/10ps

module mtp_ser_model (
  input wire logic i_tx_en,
  input wire logic [7:0] i_txd,
  input wire logic i_col_req,
  output logic o_tx_clk,
  output logic o_crs,
  output logic o_col
);
  logic [7:0] cur [$];
  logic [7:0] last [$];
  int nfr = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Clock runs free; odd offset keeps its edges 7 ns after a system clock rising edge
  initial begin
    o_tx_clk = 1'b0;
    #37;
    forever #80 o_tx_clk = ~o_tx_clk;
  end

  // Carrier echoes our own frame; collision only while the bench asks
  assign o_crs = i_tx_en;
  assign o_col = i_col_req && i_tx_en;

  // Frame closes on the first tick with enable low
  always @(posedge o_tx_clk) begin
    if (i_tx_en === 1'b1) begin
      cur.push_back(i_txd);
    end else if (cur.size() != 0) begin
      last = cur;
      cur = {};
      nfr++;
    end
  end
endmodule // mtp_ser_model

// ==== tb.sv ====
// Self-checking bench for the MAC transmit block.
// Assumes the serializer model file and the bound checker file.
`timescale 1ns/10ps

module tb;
  typedef struct {int len; logic pass; logic col; int stop; int n; logic inv;} mtp_row_t;
  localparam logic [47:0] sa_addr = 48'h02A1B2C3D4E5;
  logic i_mclk, i_rst_n, i_wr, i_rd, i_pkt_valid, i_pkt_last, i_pkt_pass_crc;
  logic i_flow_req, i_short_gap, col_req, src_on;
  logic [7:0] i_addr, i_pkt_data;
  logic [31:0] i_wdata;
  wire [31:0] o_rdata;
  wire [7:0] o_txd;
  wire o_pkt_ready, o_pkt_rewind, o_pkt_done, o_pkt_drop, o_tx_en, o_tx_er, tx_clk, crs, col;
  logic [7:0] src_buf [0:63];
  logic [7:0] f [$];
  int src_i, src_len, src_stop, seen, rew_cnt, failures, cmp_count;
  // Rows: len, pass crc, collide, bytes offered, frame size, inverted fcs
  mtp_row_t rows [4] = '{'{2, 0, 0, 2, 14, 0}, '{6, 1, 0, 6, 14, 0}, '{9, 0, 1, 9, 21, 0}, '{20, 0, 0, 5, 17, 1}};

  mtp_mac_tx i_mtp_mac_tx (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_tx_clk(tx_clk), .i_crs(crs), .i_col(col),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_pkt_valid(i_pkt_valid), .i_pkt_data(i_pkt_data), .i_pkt_last(i_pkt_last),
    .i_pkt_pass_crc(i_pkt_pass_crc), .o_pkt_ready(o_pkt_ready), .o_pkt_rewind(o_pkt_rewind),
    .o_pkt_done(o_pkt_done), .o_pkt_drop(o_pkt_drop), .i_flow_req(i_flow_req), .i_short_gap(i_short_gap),
    .o_txd(o_txd), .o_tx_en(o_tx_en), .o_tx_er(o_tx_er));
  mtp_ser_model i_mtp_ser_model (.i_tx_en(o_tx_en), .i_txd(o_txd), .i_col_req(col_req), .o_tx_clk(tx_clk),
    .o_crs(crs), .o_col(col));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  // Byte source: advance on ready, restart on rewind, stop short for underflow
  always @(posedge i_mclk) begin : src_drv
    int n;
    n = (!src_on || o_pkt_rewind) ? 0 : o_pkt_ready ? src_i + 1 : src_i;
    src_i <= n;
    i_pkt_valid <= src_on && n < src_stop;
    i_pkt_data <= src_buf[n[5:0]];
    i_pkt_last <= n == src_len - 1;
    if (o_pkt_rewind) rew_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (exp !== got) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    @(posedge i_mclk);
    chk("register read", e, o_rdata);
  endtask

  // Bounded wait on done (0), rewind (1) or enable (2)
  task automatic wait_hi(input int sel);
    int k;
    k = 0;
    while (k < 20000 && (sel == 0 ? o_pkt_done : sel == 1 ? o_pkt_rewind : o_tx_en) !== 1'b1) begin
      @(posedge i_mclk);
      k++;
    end
    chk("wait limit", 1, k < 20000);
  endtask

  task automatic get_frame();
    int k;
    k = 0;
    while (i_mtp_ser_model.nfr <= seen && k < 20000) begin
      @(posedge i_mclk);
      k++;
    end
    chk("frame seen", 1, k < 20000);
    seen++;
    f = i_mtp_ser_model.last;
  endtask

  task automatic start(input mtp_row_t r);
    col_req <= r.col;
    i_pkt_pass_crc <= r.pass;
    src_len = r.len;
    src_stop = r.stop;
    src_on <= 1'b1;
  endtask

  // Reference CRC over collected bytes, sent as the inverted remainder
  function automatic logic [31:0] crc_of(input int a, input int b);
    logic [31:0] c;
    c = 32'hFFFFFFFF;
    for (int i = a; i < b; i++) begin
      c = c ^ {24'h0, f[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
    end
    return ~c;
  endfunction

  task automatic chk_data(input mtp_row_t r);
    int n;
    n = f.size();
    chk("frame size", r.n, n);
    chk("sfd", 8'hD5, f[7]);
    for (int i = 0; i < r.stop; i++) chk("data byte", src_buf[i], f[8 + i]);
    if (!r.pass) chk("fcs", crc_of(8, n - 4) ^ {32{r.inv}}, {f[n - 1], f[n - 2], f[n - 3], f[n - 4]});
  endtask

  // Header bytes go most significant first, then zero pad to 60 bytes
  task automatic chk_pause(input logic [15:0] t);
    logic [143:0] h;
    h = {48'h0180C2000001, sa_addr, 16'h8808, 16'h0001, t};
    chk("pause size", 72, f.size());
    for (int i = 0; i < 60; i++) chk("pause byte", i < 18 ? h[143 - 8 * i -: 8] : 8'h00, f[8 + i]);
    chk("pause fcs", crc_of(8, 68), {f[71], f[70], f[69], f[68]});
  endtask

  task automatic close_out();
    $display("Comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Run is well under 10k cycles; the limit at 50k cycles leaves ample margin
  initial begin
    #1000000;
    failures++;
    $display("Error watchdog expected finish seen timeout");
    close_out();
  end

  initial begin
    {i_rst_n, i_wr, i_rd, i_pkt_valid, i_pkt_last, i_pkt_pass_crc} = 6'h00;
    {i_flow_req, i_short_gap, col_req, src_on} = 4'h0;
    {i_addr, i_pkt_data, i_wdata} = 48'h0;
    {src_i, src_len, src_stop, seen, rew_cnt, failures, cmp_count} = '0;
    for (int i = 0; i < 64; i++) src_buf[i] = 8'(i * 17 + 1);
    repeat (10) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    // Reset values, gap field width, unmapped place
    rchk(8'h00, 32'h0);
    rchk(8'h04, 32'h00C);
    wr(8'h04, 32'h3FF);
    rchk(8'h04, 32'h1FF);
    wr(8'h04, 32'h00C);
    rchk(8'h40, 32'h0);
    wr(8'h08, 32'h02A1B2C3);
    wr(8'h0C, 32'h0000D4E5);
    // Ordinary frames in full duplex, collision line active on one row
    wr(8'h00, 32'h1);
    foreach (rows[r]) begin
      start(rows[r]);
      wait_hi(0);
      src_on <= 1'b0;
      get_frame();
      chk_data(rows[r]);
    end
    chk("rewinds", 0, rew_cnt);
    // Request ignored while generation disabled, then honoured
    i_flow_req <= 1'b1;
    repeat (300) @(posedge i_mclk);
    chk("tx enable", 0, o_tx_en);
    wr(8'h00, 32'h3);
    get_frame();
    chk_pause(16'hFFFF);
    i_flow_req <= 1'b0;
    get_frame();
    chk_pause(16'h0000);
    // Request raised mid-frame waits for that frame to end
    start('{40, 0, 0, 40, 52, 0});
    wait_hi(2);
    repeat (20) @(posedge i_mclk);
    i_flow_req <= 1'b1;
    wait_hi(0);
    src_on <= 1'b0;
    get_frame();
    chk_data('{40, 0, 0, 40, 52, 0});
    get_frame();
    chk_pause(16'hFFFF);
    wr(8'h00, 32'h1);
    get_frame();
    chk_pause(16'h0000);
    i_flow_req <= 1'b0;
    // Half duplex early collision: jam, back-off, clean retry
    wr(8'h00, 32'h0);
    start('{8, 0, 1, 8, 20, 0});
    wait_hi(1);
    col_req <= 1'b0;
    get_frame();
    chk("jam byte", 8'hAA, f[f.size() - 1]);
    wait_hi(0);
    src_on <= 1'b0;
    get_frame();
    chk_data('{8, 0, 1, 8, 20, 0});
    chk("rewinds", 1, rew_cnt);
    close_out();
  end
endmodule // tb
